// *** hdl/pmii_fifo.sv ***
// Purpose: Synchronous valid/ready FIFO
// Assumes: DEPTH is a power of two
// Notes: Full and empty come from extended pointers
`timescale 1ns/1ps
`default_nettype none
module pmii_fifo #(
	parameter int WIDTH = 5,
	parameter int DEPTH = 32
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH]; // Storage
	logic [AW:0] wr_r, wr_nxt; // Write pointer with wrap bit
	logic [AW:0] rd_r, rd_nxt; // Read pointer with wrap bit
	logic push, pop;

	// Flags from pointers
	assign in_ready = ~((wr_r[AW] != rd_r[AW]) && (wr_r[AW-1:0] == rd_r[AW-1:0]));
	assign out_valid = (wr_r != rd_r);
	assign out_data = mem[rd_r[AW-1:0]];
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;

	// Pointer advance
	always_comb begin
		wr_nxt = push ? wr_r + 1'b1 : wr_r;
		rd_nxt = pop ? rd_r + 1'b1 : rd_r;
	end

	// Pointer registers
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			wr_r <= '0;
			rd_r <= '0;
		end else begin
			wr_r <= wr_nxt;
			rd_r <= rd_nxt;
		end
	end

	// Storage write
	always_ff @(posedge ref_clk) begin
		if (push) begin
			mem[wr_r[AW-1:0]] <= in_data;
		end
	end
endmodule // pmii_fifo
`default_nettype wire

// *** hdl/pmii_mac_end.sv ***
// Purpose: MAC end of the MII: nibble transfer and management master
// Assumes: Transceiver clocks arrive as pins and are synchronised
// Notes: MDC_DIV must stay at or above the rate ceiling divisor
`timescale 1ns/1ps
`default_nettype none
module pmii_mac_end
	import pmii_pkg::*;
#(
	parameter int MDC_DIV = MDC_DIV_DEF
) (
	input wire logic ref_clk,
	input wire logic rst,
	pmii_if.mac mii,
	input wire logic user_tx_valid,
	input wire logic [3:0] user_tx_nibble,
	input wire logic user_tx_err,
	output logic user_tx_ready,
	output logic user_rx_valid,
	output logic [3:0] user_rx_nibble,
	output logic user_rx_err,
	output logic user_crs,
	output logic user_col,
	input wire logic mg_start,
	input wire logic mg_write,
	input wire logic [4:0] mg_phy,
	input wire logic [4:0] mg_reg,
	input wire logic [15:0] mg_wdata,
	output logic mg_busy,
	output logic mg_done,
	output logic [15:0] mg_rdata
);
	typedef enum logic {G_IDLE, G_RUN} pmii_mgm_e;
	localparam logic [DIV_W-1:0] MDC_D = DIV_W'(MDC_DIV);

	logic [10:0] p_s1_r, p_s2_r; // {tx_clk, rx_clk, rxd, dv, er, crs, col, mdio}
	logic txc_s3_r, rxc_s3_r; // Edge history
	logic tx_rise_r, rx_rise_r;
	logic [3:0] txd_r, txd_nxt;
	logic tx_en_r, tx_en_nxt;
	logic tx_er_r, tx_er_nxt;
	logic rxv_r, rxv_nxt;
	logic [3:0] rxn_r, rxn_nxt;
	logic rxe_r, rxe_nxt;
	pmii_mgm_e g_r, g_nxt;
	logic [DIV_W-1:0] ph_r, ph_nxt; // Management clock phase
	logic [6:0] bit_r, bit_nxt; // Frame bit index
	logic [FRAME_BITS-1:0] fr_r, fr_nxt; // Outgoing frame
	logic wr_r, wr_nxt;
	logic mdc_r, mdc_nxt;
	logic oe_r, oe_nxt;
	logic done_r, done_nxt;
	logic [15:0] rd_r, rd_nxt;

	// Two-stage capture of transceiver pins
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			p_s1_r <= 11'h001;
			p_s2_r <= 11'h001;
			txc_s3_r <= 1'b0;
			rxc_s3_r <= 1'b0;
			tx_rise_r <= 1'b0;
			rx_rise_r <= 1'b0;
		end else begin
			p_s1_r <= {mii.tx_clk, mii.rx_clk, mii.rxd, mii.rx_dv, mii.rx_er,
				mii.crs, mii.col, mii.mdio};
			p_s2_r <= p_s1_r;
			txc_s3_r <= p_s2_r[10];
			rxc_s3_r <= p_s2_r[9];
			tx_rise_r <= p_s2_r[10] & ~txc_s3_r;
			rx_rise_r <= p_s2_r[9] & ~rxc_s3_r;
		end
	end

	// Launch a nibble per transmit clock rise, sample receive
	always_comb begin
		txd_nxt = txd_r;
		tx_en_nxt = tx_en_r;
		tx_er_nxt = tx_er_r;
		if (tx_rise_r) begin
			tx_en_nxt = user_tx_valid;
			txd_nxt = user_tx_valid ? user_tx_nibble : 4'h0;
			tx_er_nxt = user_tx_valid & user_tx_err;
		end
		rxv_nxt = rx_rise_r & p_s2_r[4];
		rxn_nxt = rx_rise_r ? p_s2_r[8:5] : rxn_r;
		rxe_nxt = rx_rise_r & p_s2_r[3];
	end

	// Management master
	always_comb begin
		g_nxt = g_r;
		ph_nxt = ph_r;
		bit_nxt = bit_r;
		fr_nxt = fr_r;
		wr_nxt = wr_r;
		mdc_nxt = 1'b0;
		oe_nxt = oe_r;
		done_nxt = 1'b0;
		rd_nxt = rd_r;
		unique case (g_r)
			G_IDLE: begin
				oe_nxt = 1'b0;
				if (mg_start) begin
					g_nxt = G_RUN;
					ph_nxt = 6'h00;
					bit_nxt = 7'h00;
					wr_nxt = mg_write;
					fr_nxt = {{PREAMBLE_BITS{1'b1}}, MF_START,
						mg_write ? MF_OP_WR : MF_OP_RD, mg_phy, mg_reg,
						mg_write ? MF_TA_WR : MF_TA_RD,
						mg_write ? mg_wdata : 16'hFFFF};
				end
			end
			G_RUN: begin
				ph_nxt = pmii_phase_next(ph_r, MDC_D);
				mdc_nxt = (ph_r >= (MDC_D >> 1)) | (ph_nxt >= (MDC_D >> 1));
				// Launch while low, release on read turnaround
				if (ph_r == 6'h00) begin
					oe_nxt = ~fr_r[FRAME_BITS-1] & (wr_r | bit_r < 7'(TA_POS));
				end
				// Sample on the rising edge, then advance
				if (ph_nxt == (MDC_D >> 1)) begin
					if (~wr_r && bit_r >= 7'(DATA_POS)) begin
						rd_nxt = {rd_r[14:0], p_s2_r[0]};
					end
					fr_nxt = {fr_r[FRAME_BITS-2:0], 1'b1};
					bit_nxt = bit_r + 7'h01;
				end
				if (ph_r == MDC_D - 6'h01 && bit_r == 7'(FRAME_BITS)) begin
					g_nxt = G_IDLE;
					oe_nxt = 1'b0;
					done_nxt = 1'b1;
					mdc_nxt = 1'b0;
				end
			end
			default: g_nxt = G_IDLE;
		endcase
	end

	// Registers
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			txd_r <= 4'h0;
			tx_en_r <= 1'b0;
			tx_er_r <= 1'b0;
			rxv_r <= 1'b0;
			rxn_r <= 4'h0;
			rxe_r <= 1'b0;
			g_r <= G_IDLE;
			ph_r <= 6'h00;
			bit_r <= 7'h00;
			fr_r <= '0;
			wr_r <= 1'b0;
			mdc_r <= 1'b0;
			oe_r <= 1'b0;
			done_r <= 1'b0;
			rd_r <= 16'h0000;
		end else begin
			txd_r <= txd_nxt;
			tx_en_r <= tx_en_nxt;
			tx_er_r <= tx_er_nxt;
			rxv_r <= rxv_nxt;
			rxn_r <= rxn_nxt;
			rxe_r <= rxe_nxt;
			g_r <= g_nxt;
			ph_r <= ph_nxt;
			bit_r <= bit_nxt;
			fr_r <= fr_nxt;
			wr_r <= wr_nxt;
			mdc_r <= mdc_nxt;
			oe_r <= oe_nxt;
			done_r <= done_nxt;
			rd_r <= rd_nxt;
		end
	end

	// Outputs
	assign mii.txd = txd_r;
	assign mii.tx_en = tx_en_r;
	assign mii.tx_er = tx_er_r;
	assign mii.mdc = mdc_r;
	assign mii.mdio_mac_o = 1'b0;
	assign mii.mdio_mac_oe = oe_r;
	assign user_tx_ready = tx_rise_r;
	assign user_rx_valid = rxv_r;
	assign user_rx_nibble = rxn_r;
	assign user_rx_err = rxe_r;
	assign user_crs = p_s2_r[2];
	assign user_col = p_s2_r[1];
	assign mg_busy = (g_r == G_RUN);
	assign mg_done = done_r;
	assign mg_rdata = rd_r;
endmodule // pmii_mac_end
`default_nettype wire

// *** hdl/pmii_phy_end.sv ***
// Purpose: Transceiver end of the MII: clocks, data, status, management
// Assumes: Line side runs on ref_clk; MAC pins arrive asynchronously
// Notes: Receive clock is a free divider standing in for recovery
//
// Functional notes
// - Management clock at most 25 MHz, no minimum
// - Management clock is its own asynchronous domain
// - Management data is open drain, released when idle
// - Half duplex carrier covers receive and transmit
// - Full duplex carrier covers receive only
// - Half duplex collision while transmit meets receive
// - 10 Mb/s half duplex heartbeat pulse after transmit
// - Full duplex collision always low, no heartbeat
// - Transmit clock 25 or 2.5 MHz from reference
// - MAC sends nibbles synchronous to transmit clock
// - MAC holds enable exactly while nibbles valid
// - 100 Mb/s transmit error sends HALT instead
// - 10 Mb/s transmit error is ignored
// - Receive clock 25 or 2.5 MHz
// - Receive nibble changes on receive clock fall
// - Receive valid marks nibbles, changes on fall
// - 100 Mb/s bad symbol raises receive error
`timescale 1ns/1ps
`default_nettype none
module pmii_phy_end
	import pmii_pkg::*;
#(
	parameter int FIFO_DEPTH = RX_FIFO_DEPTH
) (
	input wire logic ref_clk,
	input wire logic rst,
	pmii_if.phy mii,
	input wire logic speed_100,
	input wire logic full_duplex,
	input wire logic heartbeat_en,
	input wire logic [4:0] phy_addr,
	output logic line_tx_valid,
	output logic [3:0] line_tx_nibble,
	output logic line_tx_halt,
	input wire logic line_rx_carrier,
	input wire logic line_rx_valid,
	input wire logic [3:0] line_rx_nibble,
	input wire logic line_rx_sym_err,
	output logic line_rx_ready,
	output logic mgmt_rd,
	output logic mgmt_wr,
	output logic [4:0] mgmt_reg,
	output logic [15:0] mgmt_wdata,
	input wire logic [15:0] mgmt_rdata
);
	typedef enum logic [1:0] {M_PRE, M_HDR, M_TA, M_DATA} pmii_mg_e;

	// Pin synchronisers
	logic [5:0] txp_s1_r, txp_s2_r; // {tx_en, tx_er, txd}
	logic mdc_s1_r, mdc_s2_r, mdc_s3_r; // Management clock
	logic mdio_s1_r, mdio_s2_r; // Management data
	// Transmit side
	logic [DIV_W-1:0] div, half; // Divisor for current speed
	logic [DIV_W-1:0] tx_ph_r, tx_ph_nxt;
	logic tx_clk_r, tx_clk_nxt;
	logic tx_act_r, tx_act_nxt; // Enable as last taken
	logic ltx_v_r, ltx_v_nxt;
	logic [3:0] ltx_d_r, ltx_d_nxt;
	logic ltx_h_r, ltx_h_nxt;
	// Receive side
	logic [DIV_W-1:0] rx_ph_r, rx_ph_nxt;
	logic rx_clk_r, rx_clk_nxt;
	logic rx_fall;
	logic [3:0] rxd_r, rxd_nxt;
	logic rx_dv_r, rx_dv_nxt;
	logic rx_er_r, rx_er_nxt;
	logic fo_valid;
	logic [RX_WORD_W-1:0] fo_data;
	// Status side
	logic crs_r, crs_nxt;
	logic col_r, col_nxt;
	logic [HB_W-1:0] hb_r, hb_nxt; // Heartbeat cycles left
	// Management side
	pmii_mg_e mg_r, mg_nxt;
	logic [5:0] cnt_r, cnt_nxt; // Bit counter
	logic [HDR_BITS-1:0] hdr_r, hdr_nxt; // Header shifter
	logic [15:0] sh_r, sh_nxt; // Data shifter
	logic is_rd_r, is_rd_nxt;
	logic oe_r, oe_nxt; // Pulls the line low
	logic mrd_r, mrd_nxt;
	logic mwr_r, mwr_nxt;
	logic [4:0] mreg_r, mreg_nxt;
	logic mdc_rise;
	logic [HDR_BITS-1:0] hdr_full;

	// Receive buffer between line and MII
	pmii_fifo #(.WIDTH(RX_WORD_W), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
		.ref_clk(ref_clk),
		.rst(rst),
		.in_valid(line_rx_valid),
		.in_ready(line_rx_ready),
		.in_data({line_rx_sym_err, line_rx_nibble}),
		.out_valid(fo_valid),
		.out_ready(rx_fall),
		.out_data(fo_data)
	);

	// Two-stage capture of every pin from the MAC
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			txp_s1_r <= '0;
			txp_s2_r <= '0;
			mdc_s1_r <= 1'b0;
			mdc_s2_r <= 1'b0;
			mdc_s3_r <= 1'b0;
			mdio_s1_r <= 1'b1;
			mdio_s2_r <= 1'b1;
		end else begin
			txp_s1_r <= {mii.tx_en, mii.tx_er, mii.txd};
			txp_s2_r <= txp_s1_r;
			mdc_s1_r <= mii.mdc;
			mdc_s2_r <= mdc_s1_r;
			mdc_s3_r <= mdc_s2_r;
			mdio_s1_r <= mii.mdio;
			mdio_s2_r <= mdio_s1_r;
		end
	end

	// Transmit clock divider and nibble capture
	always_comb begin
		div = speed_100 ? DIV_100 : DIV_10;
		half = div >> 1;
		tx_ph_nxt = pmii_phase_next(tx_ph_r, div);
		tx_clk_nxt = (tx_ph_nxt < half);
		tx_act_nxt = tx_act_r;
		ltx_v_nxt = ltx_v_r;
		ltx_d_nxt = ltx_d_r;
		ltx_h_nxt = ltx_h_r;
		// Take the nibble launched at the previous rise
		if (tx_ph_r == TX_SAMPLE_PH) begin
			tx_act_nxt = txp_s2_r[5];
			ltx_v_nxt = txp_s2_r[5];
			ltx_d_nxt = txp_s2_r[3:0];
			ltx_h_nxt = speed_100 & txp_s2_r[5] & txp_s2_r[4];
		end
	end

	// Receive clock divider and nibble drive on the fall
	always_comb begin
		rx_ph_nxt = pmii_phase_next(rx_ph_r, div);
		rx_clk_nxt = (rx_ph_nxt < half);
		rx_fall = (rx_ph_nxt == half);
		rxd_nxt = rxd_r;
		rx_dv_nxt = rx_dv_r;
		rx_er_nxt = rx_er_r;
		if (rx_fall) begin
			rx_dv_nxt = fo_valid;
			rxd_nxt = fo_valid ? fo_data[3:0] : 4'h0;
			rx_er_nxt = fo_valid & speed_100 & fo_data[RX_ERR_BIT];
		end
	end

	// Clock and data registers
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			tx_ph_r <= '1; // Wraps to 0: first period is full
			tx_clk_r <= 1'b0;
			tx_act_r <= 1'b0;
			ltx_v_r <= 1'b0;
			ltx_d_r <= 4'h0;
			ltx_h_r <= 1'b0;
			rx_ph_r <= '1; // Wraps to 0: first period is full
			rx_clk_r <= 1'b0;
			rxd_r <= 4'h0;
			rx_dv_r <= 1'b0;
			rx_er_r <= 1'b0;
		end else begin
			tx_ph_r <= tx_ph_nxt;
			tx_clk_r <= tx_clk_nxt;
			tx_act_r <= tx_act_nxt;
			ltx_v_r <= ltx_v_nxt;
			ltx_d_r <= ltx_d_nxt;
			ltx_h_r <= ltx_h_nxt;
			rx_ph_r <= rx_ph_nxt;
			rx_clk_r <= rx_clk_nxt;
			rxd_r <= rxd_nxt;
			rx_dv_r <= rx_dv_nxt;
			rx_er_r <= rx_er_nxt;
		end
	end

	// Carrier, collision and heartbeat
	always_comb begin
		hb_nxt = (hb_r != '0) ? hb_r - 1'b1 : hb_r;
		// End of transmission starts the heartbeat
		if (tx_act_r & ~tx_act_nxt & ~speed_100 & ~full_duplex & heartbeat_en) begin
			hb_nxt = HB_W'(HB_CYC);
		end
		if (full_duplex) begin
			hb_nxt = '0;
		end
		crs_nxt = line_rx_carrier | rx_dv_r | (~full_duplex & tx_act_r);
		col_nxt = ~full_duplex & ((tx_act_r & (line_rx_carrier | rx_dv_r)) | (hb_r != '0));
	end

	// Status registers
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			crs_r <= 1'b0;
			col_r <= 1'b0;
			hb_r <= '0;
		end else begin
			crs_r <= crs_nxt;
			col_r <= col_nxt;
			hb_r <= hb_nxt;
		end
	end

	// Management frame decoder on rising clock edges
	always_comb begin
		mdc_rise = mdc_s2_r & ~mdc_s3_r;
		hdr_full = {hdr_r[HDR_BITS-2:0], mdio_s2_r};
		mg_nxt = mg_r;
		cnt_nxt = cnt_r;
		hdr_nxt = hdr_r;
		sh_nxt = sh_r;
		is_rd_nxt = is_rd_r;
		oe_nxt = oe_r;
		mrd_nxt = 1'b0;
		mwr_nxt = 1'b0;
		mreg_nxt = mreg_r;
		// No rate floor: only edges move the decoder
		if (mdc_rise) begin
			unique case (mg_r)
				M_PRE: begin
					// Count ones, a zero after enough opens the frame
					if (mdio_s2_r) begin
						cnt_nxt = (cnt_r == 6'(PREAMBLE_BITS)) ? cnt_r : cnt_r + 6'h01;
					end else if (cnt_r == 6'(PREAMBLE_BITS)) begin
						mg_nxt = M_HDR;
						hdr_nxt = '0;
						cnt_nxt = 6'h01;
					end else begin
						cnt_nxt = 6'h00;
					end
				end
				M_HDR: begin
					hdr_nxt = hdr_full;
					cnt_nxt = cnt_r + 6'h01;
					if (cnt_r == 6'(HDR_BITS - 1)) begin
						cnt_nxt = 6'h00;
						mg_nxt = M_PRE;
						// Start, address and opcode must match
						if (hdr_full[13:12] == MF_START && hdr_full[9:5] == phy_addr
							&& (hdr_full[11:10] == MF_OP_RD || hdr_full[11:10] == MF_OP_WR)) begin
							mg_nxt = M_TA;
							is_rd_nxt = (hdr_full[11:10] == MF_OP_RD);
							mreg_nxt = hdr_full[4:0];
							mrd_nxt = (hdr_full[11:10] == MF_OP_RD);
						end
					end
				end
				M_TA: begin
					// Second turnaround bit driven low on reads
					cnt_nxt = cnt_r + 6'h01;
					if (cnt_r == 6'h00) begin
						oe_nxt = is_rd_r;
					end else begin
						sh_nxt = mgmt_rdata;
						oe_nxt = is_rd_r & ~mgmt_rdata[15];
						mg_nxt = M_DATA;
						cnt_nxt = 6'h00;
					end
				end
				M_DATA: begin
					cnt_nxt = cnt_r + 6'h01;
					if (is_rd_r) begin
						sh_nxt = {sh_r[14:0], 1'b1};
						oe_nxt = ~sh_r[14];
					end else begin
						sh_nxt = {sh_r[14:0], mdio_s2_r};
					end
					if (cnt_r == 6'(DATA_BITS - 1)) begin
						oe_nxt = 1'b0;
						mwr_nxt = ~is_rd_r;
						mg_nxt = M_PRE;
						cnt_nxt = 6'h00;
					end
				end
			endcase
		end
	end

	// Management registers
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			mg_r <= M_PRE;
			cnt_r <= 6'h00;
			hdr_r <= '0;
			sh_r <= 16'h0000;
			is_rd_r <= 1'b0;
			oe_r <= 1'b0;
			mrd_r <= 1'b0;
			mwr_r <= 1'b0;
			mreg_r <= 5'h00;
		end else begin
			mg_r <= mg_nxt;
			cnt_r <= cnt_nxt;
			hdr_r <= hdr_nxt;
			sh_r <= sh_nxt;
			is_rd_r <= is_rd_nxt;
			oe_r <= oe_nxt;
			mrd_r <= mrd_nxt;
			mwr_r <= mwr_nxt;
			mreg_r <= mreg_nxt;
		end
	end

	// Pin and user outputs
	assign mii.tx_clk = tx_clk_r;
	assign mii.rx_clk = rx_clk_r;
	assign mii.rxd = rxd_r;
	assign mii.rx_dv = rx_dv_r;
	assign mii.rx_er = rx_er_r;
	assign mii.crs = crs_r;
	assign mii.col = col_r;
	assign mii.mdio_phy_o = 1'b0; // Open drain only pulls low
	assign mii.mdio_phy_oe = oe_r;
	assign line_tx_valid = ltx_v_r;
	assign line_tx_nibble = ltx_d_r;
	assign line_tx_halt = ltx_h_r;
	assign mgmt_rd = mrd_r;
	assign mgmt_wr = mwr_r;
	assign mgmt_reg = mreg_r;
	assign mgmt_wdata = sh_r;
endmodule // pmii_phy_end
`default_nettype wire

// *** inc/pmii_if.sv ***
// Purpose: MII pins between the transceiver end and the MAC end
// Assumes: Management data line has a pull-up on the board
// Notes: Open-drain line level is resolved here from both enables
`timescale 1ns/1ps
`default_nettype none
interface pmii_if;
	logic tx_clk; // Transmit clock, made by the transceiver
	logic [3:0] txd; // Transmit nibble
	logic tx_en; // Transmit enable
	logic tx_er; // Transmit error
	logic rx_clk; // Receive clock, made by the transceiver
	logic [3:0] rxd; // Receive nibble
	logic rx_dv; // Receive data valid
	logic rx_er; // Receive error
	logic crs; // Carrier sense
	logic col; // Collision
	logic mdc; // Management clock, made by the MAC
	logic mdio_mac_o; // MAC data out
	logic mdio_mac_oe; // MAC pulls low while high
	logic mdio_phy_o; // Transceiver data out
	logic mdio_phy_oe; // Transceiver pulls low while high
	logic mdio; // Resolved line level

	// Wired-AND with pull-up
	assign mdio = ~((mdio_mac_oe & ~mdio_mac_o) | (mdio_phy_oe & ~mdio_phy_o));

	modport phy (
		output tx_clk, rx_clk, rxd, rx_dv, rx_er, crs, col,
		output mdio_phy_o, mdio_phy_oe,
		input txd, tx_en, tx_er, mdc, mdio
	);
	modport mac (
		output txd, tx_en, tx_er, mdc, mdio_mac_o, mdio_mac_oe,
		input tx_clk, rx_clk, rxd, rx_dv, rx_er, crs, col, mdio
	);
endinterface
`default_nettype wire

// *** inc/pmii_pkg.sv ***
// Purpose: Shared constants and helpers for the MII port, both ends
// Assumes: 125 MHz reference clock on every end
// Notes: Transceiver clock ratios are derived from rates; the default management divisor is a typed count
`default_nettype none
package pmii_pkg;
	// Clock rates in kHz
	localparam int CLK_KHZ = 125000;
	localparam int MII_KHZ_100 = 25000;
	localparam int MII_KHZ_10 = 2500;
	localparam int MDC_KHZ_MAX = 25000;
	// Divider phase counter width
	localparam int DIV_W = 6;
	localparam logic [DIV_W-1:0] DIV_100 = DIV_W'(CLK_KHZ / MII_KHZ_100);
	localparam logic [DIV_W-1:0] DIV_10 = DIV_W'(CLK_KHZ / MII_KHZ_10);
	// Least management clock divisor for the rate ceiling
	localparam int MDC_DIV_MIN = CLK_KHZ / MDC_KHZ_MAX;
	// Default divisor, leaves room for pin synchronisers
	localparam int MDC_DIV_DEF = 10;
	// Phase after a transmit clock rise where the nibble is taken
	localparam logic [DIV_W-1:0] TX_SAMPLE_PH = 6'h03;
	// Heartbeat pulse length
	localparam int HB_NS = 1000;
	localparam int HB_CYC = (HB_NS * CLK_KHZ) / 1000000;
	localparam int HB_W = 8;
	// Receive buffer: error flag above the nibble
	localparam int RX_FIFO_DEPTH = 32;
	localparam int RX_WORD_W = 5;
	localparam int RX_ERR_BIT = 4;
	// Management frame layout
	localparam int PREAMBLE_BITS = 32;
	localparam int HDR_BITS = 14;
	localparam int DATA_BITS = 16;
	localparam int FRAME_BITS = 64;
	localparam int TA_POS = PREAMBLE_BITS + HDR_BITS;
	localparam int DATA_POS = TA_POS + 2;
	localparam logic [1:0] MF_START = 2'h1;
	localparam logic [1:0] MF_OP_RD = 2'h2;
	localparam logic [1:0] MF_OP_WR = 2'h1;
	localparam logic [1:0] MF_TA_WR = 2'h2;
	localparam logic [1:0] MF_TA_RD = 2'h3;

	// Next phase of a wrapping divider counter
	function automatic logic [DIV_W-1:0] pmii_phase_next(
		input logic [DIV_W-1:0] ph,
		input logic [DIV_W-1:0] div
	);
		return (ph >= div - 6'h01) ? 6'h00 : ph + 6'h01;
	endfunction
endpackage
`default_nettype wire

// *** tb/pmii_props.sv ***
// Purpose: Concurrent checks on the MII pins between both ends
// Assumes: Mode inputs change only while rst is high
// Notes: Clock high times are measured by run-length counters
`timescale 1ns/1ps
`default_nettype none
module pmii_props (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic speed_100,
	input wire logic full_duplex,
	input wire logic tx_clk,
	input wire logic tx_en,
	input wire logic rx_clk,
	input wire logic [3:0] rxd,
	input wire logic rx_dv,
	input wire logic rx_er,
	input wire logic crs,
	input wire logic col,
	input wire logic mdc,
	input wire logic mdio_mac_oe,
	input wire logic mdio_phy_oe
);
	logic [5:0] tx_run_r, tx_run_nxt; // Cycles since tx_clk moved
	logic [5:0] rx_run_r, rx_run_nxt; // Cycles since rx_clk moved
	logic tx_prev_r, tx_prev_nxt, rx_prev_r, rx_prev_nxt;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	// Counters restart whenever a clock pin changes
	always_comb begin
		tx_prev_nxt = rst ? 1'b0 : tx_clk;
		rx_prev_nxt = rst ? 1'b0 : rx_clk;
		tx_run_nxt = (rst || tx_clk != tx_prev_r) ? 6'h00 : tx_run_r + 6'h01;
		rx_run_nxt = (rst || rx_clk != rx_prev_r) ? 6'h00 : rx_run_r + 6'h01;
	end
	// Registers only
	always_ff @(posedge ref_clk) begin
		tx_prev_r <= tx_prev_nxt;
		rx_prev_r <= rx_prev_nxt;
		tx_run_r <= tx_run_nxt;
		rx_run_r <= rx_run_nxt;
	end
	// Four quiet cycles after each management clock rise
	sequence s_mdc_gap;
		!$rose(mdc) [*4];
	endsequence
	AST_MDC_RATE: assert property ($rose(mdc) |=> s_mdc_gap)
		else $error("management clock too fast");
	AST_MDIO_ONE: assert property (!(mdio_mac_oe && mdio_phy_oe))
		else $error("both ends drive management data");
	AST_CRS_RX: assert property (rx_dv |-> ##[0:3] crs)
		else $error("no carrier for receive");
	AST_CRS_TX: assert property (!full_duplex && tx_en |-> ##[0:60] crs)
		else $error("no carrier for transmit");
	AST_COL_HD: assert property (!full_duplex && tx_en && rx_dv |-> ##[0:60] col)
		else $error("no collision");
	AST_COL_FD: assert property (full_duplex && $past(full_duplex) |-> !col)
		else $error("collision in full duplex");
	AST_TX_HIGH: assert property ($fell(tx_clk) |-> tx_run_r == (speed_100 ? 6'h01 : 6'h18))
		else $error("transmit clock high time wrong");
	AST_RX_HIGH: assert property ($fell(rx_clk) |-> rx_run_r == (speed_100 ? 6'h01 : 6'h18))
		else $error("receive clock high time wrong");
	AST_RX_EDGE: assert property (!$stable({rxd, rx_dv, rx_er}) |-> $fell(rx_clk))
		else $error("receive outputs moved off the falling edge");
	AST_RXER_10: assert property (!speed_100 |-> !rx_er)
		else $error("receive error at low speed");
endmodule // pmii_props
`default_nettype wire

// *** tb/tb.sv ***
// Purpose: Self-checking bench joining both MII ends
// Assumes: Modes change only while rst is held
// Notes: Line and user sides are driven and watched here
`timescale 1ns/1ps
`default_nettype none
module tb;
	import pmii_pkg::*;
	logic ref_clk = 1'b0, rst = 1'b1; // 125 MHz clock
	logic speed_100 = 1'b1, full_duplex = 1'b0, heartbeat_en = 1'b0;
	logic line_tx_valid, line_tx_halt, line_rx_ready, mgmt_rd, mgmt_wr;
	logic [3:0] line_tx_nibble, user_rx_nibble;
	logic line_rx_carrier = 1'b0, line_rx_valid = 1'b0, line_rx_sym_err = 1'b0;
	logic [3:0] line_rx_nibble = 4'h0, user_tx_nibble = 4'h0;
	logic [4:0] mgmt_reg, mg_phy = 5'h00, mg_reg = 5'h00;
	logic [15:0] mgmt_wdata, mgmt_rdata, mg_rdata, mg_wdata = 16'h0000;
	logic user_tx_valid = 1'b0, user_tx_err = 1'b0, user_tx_ready;
	logic user_rx_valid, user_rx_err, mg_done, mg_start = 1'b0, mg_write = 1'b0;
	int bad_count = 0, cmp_count = 0, col_cnt = 0, crs_cnt = 0, rd_cnt = 0;
	logic user_crs, user_col; // Status as the MAC end sees it
	logic full_seen = 1'b0; // Line push was refused
	logic [4:0] txq[$], txe[$], rxq[$], rxe[$]; // Seen and expected
	logic [20:0] wq[$]; // Register writes seen
	always #4 ref_clk = ~ref_clk;
	pmii_if mii ();
	pmii_phy_end pmii_phy_end_inst (.ref_clk(ref_clk), .rst(rst), .mii(mii),
		.speed_100(speed_100), .full_duplex(full_duplex),
		.heartbeat_en(heartbeat_en), .phy_addr(5'h0B),
		.line_tx_valid(line_tx_valid), .line_tx_nibble(line_tx_nibble),
		.line_tx_halt(line_tx_halt), .line_rx_carrier(line_rx_carrier),
		.line_rx_valid(line_rx_valid), .line_rx_nibble(line_rx_nibble),
		.line_rx_sym_err(line_rx_sym_err), .line_rx_ready(line_rx_ready),
		.mgmt_rd(mgmt_rd), .mgmt_wr(mgmt_wr), .mgmt_reg(mgmt_reg),
		.mgmt_wdata(mgmt_wdata), .mgmt_rdata(mgmt_rdata));
	pmii_mac_end pmii_mac_end_inst (.ref_clk(ref_clk), .rst(rst), .mii(mii),
		.user_tx_valid(user_tx_valid), .user_tx_nibble(user_tx_nibble),
		.user_tx_err(user_tx_err), .user_tx_ready(user_tx_ready),
		.user_rx_valid(user_rx_valid), .user_rx_nibble(user_rx_nibble),
		.user_rx_err(user_rx_err), .user_crs(user_crs),
		.user_col(user_col),
		.mg_start(mg_start), .mg_write(mg_write), .mg_phy(mg_phy),
		.mg_reg(mg_reg), .mg_wdata(mg_wdata), .mg_busy(), .mg_done(mg_done),
		.mg_rdata(mg_rdata));
	pmii_props pmii_props_inst (.ref_clk(ref_clk), .rst(rst),
		.speed_100(speed_100), .full_duplex(full_duplex), .tx_clk(mii.tx_clk),
		.tx_en(mii.tx_en), .rx_clk(mii.rx_clk), .rxd(mii.rxd),
		.rx_dv(mii.rx_dv), .rx_er(mii.rx_er), .crs(mii.crs), .col(mii.col),
		.mdc(mii.mdc), .mdio_mac_oe(mii.mdio_mac_oe),
		.mdio_phy_oe(mii.mdio_phy_oe));
	// Register file answer derived from the address
	assign mgmt_rdata = 16'hA500 | {11'h000, mgmt_reg};
	// Line nibbles once per transmit clock period
	always @(posedge mii.tx_clk) begin
		if (line_tx_valid === 1'b1) txq.push_back({line_tx_halt, line_tx_nibble});
	end
	// User side nibbles, register strobes, status time, mid-cycle
	always @(negedge ref_clk) begin
		if (user_rx_valid === 1'b1) rxq.push_back({user_rx_err, user_rx_nibble});
		if (mgmt_wr === 1'b1) wq.push_back({mgmt_reg, mgmt_wdata});
		if (mgmt_rd === 1'b1) rd_cnt++;
		if (user_col === 1'b1) col_cnt++;
		if (user_crs === 1'b1) crs_cnt++;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	task automatic check(input string what, input logic [20:0] exp, input logic [20:0] got);
		cmp_count++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	// New mode under reset, then fresh status counts and full flag
	task automatic mode(input logic s, input logic f, input logic h);
		rst = 1'b1;
		speed_100 = s;
		full_duplex = f;
		heartbeat_en = h;
		tick(2);
		rst = 1'b0;
		tick(2);
		col_cnt = 0;
		crs_cnt = 0;
		full_seen = 1'b0;
	endtask
	// Frame of nibbles, error on index bad
	task automatic frame(input int cnt, input int bad);
		int k;
		user_tx_valid = 1'b1;
		for (int i = 0; i < cnt; i++) begin
			user_tx_nibble = 4'(i + 3);
			user_tx_err = (i == bad);
			txe.push_back({speed_100 && i == bad, 4'(i + 3)});
			// Ready seen now means taken at the coming edge
			for (k = 0; user_tx_ready !== 1'b1 && k < 200; k++) tick(1);
			tick(1);
		end
		user_tx_valid = 1'b0;
		tick(400);
		check("tx count", 21'(txe.size()), 21'(txq.size()));
		foreach (txe[i]) check("tx", 21'(txe[i]), 21'(txq[i]));
		txe.delete();
		txq.delete();
	endtask
	// Line words, pushed whenever the buffer takes them
	task automatic rx_burst(input int cnt);
		int k;
		line_rx_valid = 1'b1;
		for (int i = 0; i < cnt; i++) begin
			line_rx_nibble = 4'(i);
			line_rx_sym_err = (i % 5 == 1);
			rxe.push_back({speed_100 && i % 5 == 1, 4'(i)});
			for (k = 0; line_rx_ready !== 1'b1 && k < 500; k++) begin
				full_seen = 1'b1;
				tick(1);
			end
			tick(1);
		end
		line_rx_valid = 1'b0;
	endtask
	task automatic rx_cmp();
		for (int k = 0; k < 6000 && rxq.size() < rxe.size(); k++) tick(1);
		check("rx count", 21'(rxe.size()), 21'(rxq.size()));
		foreach (rxe[i]) check("rx", 21'(rxe[i]), 21'(rxq[i]));
		rxe.delete();
		rxq.delete();
	endtask
	// One management frame, waits for completion
	task automatic mg(input logic w, input logic [4:0] ph, input logic [4:0] r, input logic [15:0] d);
		int k;
		mg_write = w;
		mg_phy = ph;
		mg_reg = r;
		mg_wdata = d;
		mg_start = 1'b1;
		tick(1);
		mg_start = 1'b0;
		for (k = 0; mg_done !== 1'b1 && k < 1000; k++) tick(1);
		tick(20);
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	// Watchdog well beyond the expected run
	initial begin
		#400000;
		bad_count++;
		summarize();
	end
	initial begin
		tick(14);
		mode(1'b1, 1'b0, 1'b0);
		frame(6, 2);
		check("crs on transmit", 21'h1, 21'(crs_cnt > 0));
		rx_burst(8);
		rx_cmp();
		mode(1'b0, 1'b0, 1'b0);
		line_rx_carrier = 1'b1;
		rx_burst(40);
		frame(4, 1);
		check("collision", 21'h1, 21'(col_cnt > 0));
		check("buffer full", 21'h1, 21'(full_seen));
		rx_cmp();
		line_rx_carrier = 1'b0;
		mode(1'b0, 1'b0, 1'b1);
		frame(4, 9);
		check("heartbeat", 21'(HB_CYC), 21'(col_cnt));
		mode(1'b0, 1'b1, 1'b1);
		frame(4, 9);
		check("full duplex col", 21'h0, 21'(col_cnt));
		check("full duplex crs", 21'h0, 21'(crs_cnt));
		mode(1'b1, 1'b0, 1'b0);
		mg(1'b1, 5'h0B, 5'h05, 16'h3C5A);
		check("write", {5'h05, 16'h3C5A}, wq.size() > 0 ? wq[0] : 21'h0);
		mg(1'b0, 5'h0B, 5'h09, 16'h0000);
		check("read", 21'h0A509, {5'h00, mg_rdata});
		check("read strobe", 21'h1, 21'(rd_cnt));
		mg(1'b1, 5'h0C, 5'h05, 16'h1111);
		check("other address", 21'h1, 21'(wq.size()));
		summarize();
	end
endmodule // tb
`default_nettype wire
